// ===== src/dpr_host_pkg.sv
// constants, types and register map of the dual-port ram host controller
// assumes a 100 MHz pclk and one asynchronous port of the memory on pins
`default_nettype none
package dpr_host_pkg;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 9;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int SYNC_STAGES = 2;

  // --------------------------------------------------------------
  // pin timing of the memory, in ns
  // --------------------------------------------------------------
  localparam int T_PWE_NS = 12;
  localparam int T_SD_NS = 10;
  localparam int T_HZWE_NS = 10;
  localparam int T_AA_NS = 15;
  localparam int T_SOP_NS = 10;

  // least time in whole cycles, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  typedef logic [2:0] cnt_t;
  localparam cnt_t WR_CYC =
    cnt_t'(max2(cyc_min(T_PWE_NS), cyc_min(T_HZWE_NS + T_SD_NS)));
  localparam cnt_t RD_CYC = cnt_t'(cyc_min(T_AA_NS) + SYNC_STAGES);
  localparam cnt_t REC_CYC = cnt_t'(cyc_min(T_SOP_NS));

  // --------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  localparam int ST_ACTIVE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_MAIL = 2;
  localparam int ST_CONTENDED = 3;
  localparam int ST_REFUSED = 4;

  localparam logic [ADDR_W-1:0] MAIL_TO_RIGHT = 13'h1FFF;
  localparam logic [ADDR_W-1:0] MAIL_TO_LEFT = 13'h1FFE;

  typedef enum logic [1:0] {
    OP_MEM_RD = 2'h0,
    OP_MEM_WR = 2'h1,
    OP_TOK_WR = 2'h2,
    OP_TOK_RD = 2'h3
  } op_e;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_SETUP = 4'h2,
    S_ACCESS = 4'h4,
    S_RECOVER = 4'h8
  } state_e;

endpackage
`default_nettype wire

// ===== src/pin_sync_if.sv
// raw and synchronised copies of the asynchronous memory inputs
// assumes one clock on both ends
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
  logic [8:0] dq_raw;
  logic busy_n_raw;
  logic int_n_raw;
  logic [8:0] dq;
  logic busy_n;
  logic int_n;
  modport top (output dq_raw, busy_n_raw, int_n_raw,
               input dq, busy_n, int_n);
  modport sync (input dq_raw, busy_n_raw, int_n_raw,
                output dq, busy_n, int_n);
endinterface
`default_nettype wire

// ===== src/pin_sync.sv
// two-flop synchronisers for the memory's data, contention and mail pins
// assumes the pins are stable long enough for two pclk edges
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins in, levels out
  pin_sync_if.sync sig
);
  logic [10:0] meta;
  logic [10:0] stable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 11'h600;
      stable <= 11'h600;
    end else begin
      meta <= {sig.busy_n_raw, sig.int_n_raw, sig.dq_raw};
      stable <= meta;
    end
  end

  assign sig.busy_n = stable[10];
  assign sig.int_n = stable[9];
  assign sig.dq = stable[8:0];
endmodule // pin_sync
`default_nettype wire

// ===== src/dpr_host.sv
// host controller for one port of an asynchronous dual-port ram
// assumes software on apb and the memory port on plain pins
`timescale 1ns/1ps
`default_nettype none
module dpr_host
  import dpr_host_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory port
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] dq_in,
  output logic port_select_n,
  output logic output_gate_n,
  output logic read_write_n,
  output logic token_latch_select_n,
  input wire logic contention_n,
  input wire logic mailbox_n
);

  pin_sync_if sif ();
  assign sif.dq_raw = dq_in;
  assign sif.busy_n_raw = contention_n;
  assign sif.int_n_raw = mailbox_n;

  pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sig(sif.sync)
  );

  state_e state;
  state_e next_state;
  op_e op;
  cnt_t cnt;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic contended;
  logic refused;
  logic take;
  logic start;
  logic is_wr;
  logic is_mem;
  logic access_end;

  // ------------------------------------------------------------
  // apb slave: one wait state, answer from a flop
  // ------------------------------------------------------------
  assign take = psel && penable && pready;
  assign start = take && pwrite && paddr == REG_CMD && state == S_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pslverr <= 1'b0;
      unique case (paddr)
        REG_ADDR: prdata <= {19'h0, addr_reg};
        REG_WDATA: prdata <= {23'h0, wdata_reg};
        REG_RDATA: prdata <= {23'h0, rdata_reg};
        REG_STATUS: prdata <= {27'h0, refused, contended, !sif.int_n,
                               !sif.busy_n, state != S_IDLE};
        REG_CMD: prdata <= {30'h0, op};
        default: begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= 13'h0000;
      wdata_reg <= 9'h000;
      op <= OP_MEM_RD;
    end else if (take && pwrite) begin
      if (paddr == REG_ADDR) addr_reg <= pwdata[ADDR_W-1:0];
      if (paddr == REG_WDATA) wdata_reg <= pwdata[DATA_W-1:0];
      if (start) op <= op_e'(pwdata[1:0]);
    end
  end

  // refused command while busy; set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused <= 1'b0;
    end else if (take && pwrite && paddr == REG_CMD && state != S_IDLE) begin
      refused <= 1'b1;
    end else if (take && pwrite && paddr == REG_STATUS &&
                 pwdata[ST_REFUSED]) begin
      refused <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // pin sequencer
  // ------------------------------------------------------------
  assign is_wr = op == OP_MEM_WR || op == OP_TOK_WR;
  assign is_mem = op == OP_MEM_RD || op == OP_MEM_WR;
  assign access_end = cnt == (is_wr ? WR_CYC : RD_CYC) - 3'h1;

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: if (start) next_state = S_SETUP;
      // a write on a contended location is held off until released
      S_SETUP: if (!(op == OP_MEM_WR && !sif.busy_n))
        next_state = S_ACCESS;
      S_ACCESS: if (access_end) next_state = S_RECOVER;
      // selects stay high for the flag update pulse before any new access
      S_RECOVER: if (cnt == REC_CYC - 3'h1) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      cnt <= 3'h0;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? 3'h0 : cnt + 3'h1;
    end
  end

  // pins follow the next state so each one is a plain flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr <= 13'h0000;
      dq_out <= 9'h000;
      dq_oe <= 1'b0;
      port_select_n <= 1'b1;
      output_gate_n <= 1'b1;
      read_write_n <= 1'b1;
      token_latch_select_n <= 1'b1;
    end else begin
      if (next_state == S_SETUP) begin
        mem_addr <= addr_reg;
        dq_out <= wdata_reg;
      end
      // write strobe is the overlap of select and read_write_n
      read_write_n <= !(next_state == S_ACCESS && is_wr);
      port_select_n <= !(next_state == S_ACCESS && is_mem);
      token_latch_select_n <= !(next_state == S_ACCESS && !is_mem);
      // gate held high on writes, so the shortest pulse suffices
      output_gate_n <= !(next_state == S_ACCESS && !is_wr);
      // data held through the edge where the write ends
      dq_oe <= is_wr && (next_state == S_ACCESS ||
                         next_state == S_RECOVER);
    end
  end

  // token value appears on every line; bit zero alone is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 9'h000;
    end else if (state == S_ACCESS && access_end && !is_wr) begin
      rdata_reg <= is_mem ? sif.dq : {8'h00, sif.dq[0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contended <= 1'b0;
    end else if (state == S_ACCESS && is_mem && !sif.busy_n) begin
      contended <= 1'b1;
    end else if (start) begin
      contended <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_addr_rw_high:
    assert property ($changed(mem_addr) |-> read_write_n)
    else $error("address moved while read_write_n low");
  a_write_pulse_len:
    assert property ($fell(read_write_n) |-> !read_write_n[*2])
    else $error("write pulse shorter than two cycles");
  a_data_hold_end:
    assert property ($rose(read_write_n) |-> dq_oe)
    else $error("data released before write end");
  a_gate_high_write:
    assert property (!read_write_n |-> output_gate_n && dq_oe)
    else $error("output gate low during write");
  a_token_select_high:
    assert property (!token_latch_select_n |-> port_select_n)
    else $error("port select low during token access");
  a_token_gap:
    assert property ($rose(token_latch_select_n) |=> token_latch_select_n)
    else $error("token select pulsed without a gap");
  a_busy_holds_write:
    assert property (state == S_SETUP && op == OP_MEM_WR && !sif.busy_n
                     |=> read_write_n && port_select_n)
    else $error("write started while contention flagged");
  a_read_capture:
    assert property (state == S_ACCESS && op == OP_TOK_RD && access_end
                     |=> rdata_reg[8:1] == 8'h00)
    else $error("token read kept more than bit zero");
  a_apb_answer:
    assert property (psel && penable && !pready |=> pready)
    else $error("apb answer missing");

  c_mem_write: cover property ($fell(read_write_n) && !port_select_n);
  c_mem_read: cover property ($fell(output_gate_n) && !port_select_n);
  c_token_write:
    cover property ($fell(read_write_n) && !token_latch_select_n);
  c_contended: cover property (state == S_SETUP && !sif.busy_n);
  c_mailbox: cover property ($fell(sif.int_n));

endmodule // dpr_host
`default_nettype wire

// ===== dv/dpr_port_model.sv
// behavioural model of the host's port of the dual-port ram
// assumes the bench plays the far port through busy_req, mail and hold
`timescale 1ns/1ps
`default_nettype none
module dpr_port_model
  import dpr_host_pkg::*;
(
  // memory pins
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  output logic [DATA_W-1:0] dq_in,
  input wire logic port_select_n,
  input wire logic output_gate_n,
  input wire logic read_write_n,
  input wire logic token_latch_select_n,
  output logic contention_n,
  output logic mailbox_n,
  // actions of the far port
  input wire logic busy_req,
  input wire logic other_mail_wr,
  input wire logic [7:0] other_hold
);
  logic [DATA_W-1:0] mem [0:8191];
  logic [7:0] req = 8'h00;
  logic [7:0] granted = 8'h00;
  logic [DATA_W-1:0] tok_q = '0;
  logic [DATA_W-1:0] held = '0;
  logic right_mail = 1'b0;
  logic wr_mem, wr_tok, rd_mem, rd_tok, rd_mail, drv;
  initial mailbox_n = 1'b1;
  assign contention_n = ~busy_req;
  assign wr_mem = !port_select_n && !read_write_n && contention_n;
  assign wr_tok = !token_latch_select_n && !read_write_n;
  assign rd_mem = !port_select_n && read_write_n && !output_gate_n;
  assign rd_tok = !token_latch_select_n && read_write_n && !output_gate_n;
  assign rd_mail = rd_mem && mem_addr == MAIL_TO_LEFT;
  assign drv = dq_oe || rd_mem || rd_tok;
  // released lines show the inverse of the last value, never a lucky match
  assign dq_in = dq_oe ? dq_out : rd_mem ? mem[mem_addr] :
                 rd_tok ? tok_q : ~held;
  always @(dq_in) if (drv) held = dq_in;
  // data is taken at the edge that ends the write
  always @(negedge wr_mem) mem[mem_addr] = dq_out;
  // the far port's mail flag, raised by our write of its word
  always @(negedge wr_mem)
    if (mem_addr == MAIL_TO_RIGHT) right_mail = 1'b1;
  always @(negedge wr_tok) req[mem_addr[2:0]] = ~dq_out[0];
  // a pending request wins as soon as the far side lets go
  always @(req or other_hold)
    granted = req & (granted | ~other_hold);
  always @(posedge rd_tok) tok_q = {DATA_W{~granted[mem_addr[2:0]]}};
  always @(posedge other_mail_wr or posedge rd_mail)
    mailbox_n = rd_mail;
endmodule // dpr_port_model
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench: apb master tasks driving the host controller
// assumes dpr_host and the port model above; one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x); end end
module tb_top;
  import dpr_host_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, dq_oe, port_select_n, output_gate_n;
  logic read_write_n, token_latch_select_n, contention_n, mailbox_n;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] dq_out, dq_in;
  logic busy_req = 1'b0;
  logic other_mail_wr = 1'b0;
  logic [7:0] other_hold = 8'h00;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [ADDR_W-1:0] addrs [3] = '{13'h0000, 13'h0ABC, 13'h1FFF};

  dpr_host u_dpr_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mem_addr, .dq_out, .dq_oe, .dq_in,
    .port_select_n, .output_gate_n, .read_write_n, .token_latch_select_n,
    .contention_n, .mailbox_n);
  dpr_port_model u_dpr_port_model (.mem_addr, .dq_out, .dq_oe, .dq_in,
    .port_select_n, .output_gate_n, .read_write_n, .token_latch_select_n,
    .contention_n, .mailbox_n, .busy_req, .other_mail_wr, .other_hold);

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // pin-order checks on what the controller drives
  always @(mem_addr) if (presetn === 1'b1) `CHK(read_write_n, 1'b1)
  always @(negedge read_write_n) `CHK(output_gate_n, 1'b1)
  always @(negedge token_latch_select_n) `CHK(port_select_n, 1'b1)

  task automatic complete_run();
    $display("errors=%0d checks=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic op(input op_e o, input logic [12:0] a, input logic [8:0] d);
    xfer(1'b1, REG_ADDR, 32'(a));
    xfer(1'b1, REG_WDATA, 32'(d));
    xfer(1'b1, REG_CMD, 32'(o));
    do xfer(1'b0, REG_STATUS, 32'h0); while (r[ST_ACTIVE] !== 1'b0);
  endtask

  task automatic rd_chk(input op_e o, input logic [12:0] a,
                        input logic [31:0] x);
    op(o, a, 9'h000);
    xfer(1'b0, REG_RDATA, 32'h0);
    `CHK(r, x)
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, REG_STATUS, 32'h0);
    `CHK(r, 32'h0)
    foreach (addrs[i]) begin
      op(OP_MEM_WR, addrs[i], 9'h1A5 ^ 9'(i));
      `CHK(u_dpr_port_model.mem[addrs[i]], 9'h1A5 ^ 9'(i))
      rd_chk(OP_MEM_RD, addrs[i], {23'h0, 9'h1A5 ^ 9'(i)});
    end
    `CHK(u_dpr_port_model.right_mail, 1'b1)
    // far port posts mail, our read of its word clears it
    @(posedge pclk) other_mail_wr <= 1'b1;
    @(posedge pclk) other_mail_wr <= 1'b0;
    xfer(1'b0, REG_STATUS, 32'h0);
    `CHK(r[ST_MAIL], 1'b1)
    op(OP_MEM_RD, MAIL_TO_LEFT, 9'h000);
    xfer(1'b0, REG_STATUS, 32'h0);
    `CHK(r[ST_MAIL], 1'b0)
    op(OP_TOK_WR, 13'h0003, 9'h000);
    rd_chk(OP_TOK_RD, 13'h0003, 32'h0);
    other_hold <= 8'h20;
    op(OP_TOK_WR, 13'h0005, 9'h000);
    rd_chk(OP_TOK_RD, 13'h0005, 32'h1);
    other_hold <= 8'h00;
    rd_chk(OP_TOK_RD, 13'h0005, 32'h0);
    op(OP_TOK_WR, 13'h0005, 9'h001);
    rd_chk(OP_TOK_RD, 13'h0005, 32'h1);
    // a write held off by the contention flag, then let through
    op(OP_MEM_WR, 13'h0100, 9'h0AA);
    busy_req <= 1'b1;
    xfer(1'b1, REG_WDATA, 32'h55);
    xfer(1'b1, REG_CMD, 32'(OP_MEM_WR));
    repeat (20) @(posedge pclk);
    xfer(1'b0, REG_STATUS, 32'h0);
    `CHK(r[1:0], 2'b11)
    `CHK(u_dpr_port_model.mem[13'h0100], 9'h0AA)
    xfer(1'b1, REG_CMD, 32'(OP_MEM_RD));
    xfer(1'b0, REG_STATUS, 32'h0);
    `CHK(r[ST_REFUSED], 1'b1)
    busy_req <= 1'b0;
    do xfer(1'b0, REG_STATUS, 32'h0); while (r[ST_ACTIVE] !== 1'b0);
    // flag was gone before the access began, so no contention is recorded
    `CHK(r[ST_CONTENDED], 1'b0)
    `CHK(u_dpr_port_model.mem[13'h0100], 9'h055)
    // a read during a flagged access is recorded as contended
    busy_req <= 1'b1;
    rd_chk(OP_MEM_RD, 13'h0100, 32'h55);
    busy_req <= 1'b0;
    xfer(1'b0, REG_STATUS, 32'h0);
    `CHK(r[ST_CONTENDED], 1'b1)
    xfer(1'b1, REG_STATUS, 32'h10);
    xfer(1'b0, REG_STATUS, 32'h0);
    `CHK(r[ST_REFUSED], 1'b0)
    xfer(1'b0, 8'h40, 32'h0);
    `CHK({e, r}, {1'b1, 32'h0})
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
